// File: design/tse_uart.v
// Timer-and-shifter UART: independent transmit and receive channels,
// 8N1 framing, registers on a classic Wishbone slave.
// Assumes inputs synchronous to clock; rxPin is resynchronised anyway.
// Behaviour
// [R1] Frames are eight data bits, one stop bit, no parity, no flow control.
// [R2] Transmitter adds start and stop bits itself around each byte.
// [R3] No parity is generated; software must handle any parity scheme.
// [R4] Transmit and receive each own timer, shifter and pin, run alone.
// [R5] Bit rate up to 115200 baud; dividers clamp below that rate.
// [R6] Byte written to transmit buffer is shifted LSB first onto pin.
// [R7] Transmit-ready flag shows next frame may go; pollable, interrupt-able.
// [R8] Receiver samples only on store events, then moves byte to buffer.
// [R9] Receive-full flag shows a byte waits; pollable, interrupt-able.
// [R10] A bit-reversed read view of the receive buffer is provided.
// [R11] Bad stop bit sets a framing-error flag visible to software.
// [R12] No automatic break or idle character generation or detection.
// [R13] Remote end must use the same rate and 8N1 format.
// [R14] Line idles high; start low, stop high, one timer period each.
// [R15] Receive timer starts on start edge, stores mid-bit.
//
// The placing of the registers and the Wishbone register port were decided locally.
`include "tse_uart_consts.vh"

module tse_uart (
	// System
	input wire clock,
	input wire nrst,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [4:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output wire wb_err_o,
	// Serial pins
	output reg txPin,
	input wire rxPin,
	// Per-direction interrupt requests
	output wire txIrq,
	output wire rxIrq
);

	localparam TX_IDLE = 4'h1;
	localparam TX_START = 4'h2;
	localparam TX_DATA = 4'h4;
	localparam TX_STOP = 4'h8;
	localparam RX_IDLE = 4'h1;
	localparam RX_START = 4'h2;
	localparam RX_DATA = 4'h4;
	localparam RX_STOP = 4'h8;

	reg [3:0] ctrl;
	reg [15:0] txDiv;
	reg [15:0] rxDiv;
	reg [7:0] txBuf;
	reg txFull;
	reg [7:0] txShift;
	reg [3:0] txState;
	reg [15:0] txTimer;
	reg [2:0] txBit;
	reg [7:0] rxBuf;
	reg rxFull;
	reg frameErr;
	reg rxOvr;
	reg [7:0] rxShift;
	reg [3:0] rxState;
	reg [15:0] rxTimer;
	reg [2:0] rxBit;
	reg rxMeta;
	reg rxSync;
	reg rxPrev;

	wire access;
	wire wrStb;
	wire rdStb;
	wire hit;
	wire [15:0] txPeriod;
	wire [15:0] rxPeriod;
	wire txTick;
	wire rxTick;
	wire txLoad;
	wire rxStore;
	wire rxDone;
	wire [7:0] rxRev;
	wire [15:0] minDiv;
	wire txReady;
	reg [31:0] next_rdData;

	// Bus decode: one-cycle answer, err on unmapped word
	assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign hit = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i <= `TSE_OFF_RXDIV);
	assign wrStb = access & wb_we_i & hit & wb_sel_i[0];
	assign rdStb = access & ~wb_we_i & hit;
	assign wb_err_o = wb_cyc_i & wb_stb_i & ~hit;

	// Dividers held at or above the top-rate period
	assign minDiv = `TSE_MIN_DIV;
	assign txPeriod = (txDiv < minDiv) ? minDiv : txDiv; // R5
	assign rxPeriod = (rxDiv < minDiv) ? minDiv : rxDiv; // R5

	assign txReady = ~txFull;
	assign txIrq = ctrl[`TSE_CTRL_TXIE] & ctrl[`TSE_CTRL_TXEN] & txReady; // R7
	assign rxIrq = ctrl[`TSE_CTRL_RXIE] & rxFull; // R9

	// Mirrored view of the receive buffer
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : revGen
			assign rxRev[gi] = rxBuf[7 - gi]; // R10
		end
	endgenerate

	// Read mux
	always @* begin
		next_rdData = 32'h0;
		case (wb_adr_i)
			`TSE_OFF_CTRL: next_rdData = {28'h0, ctrl};
			`TSE_OFF_STAT: next_rdData = {27'h0, rxOvr, ~txState[0],
				frameErr, rxFull, txReady};
			`TSE_OFF_TXBUF: next_rdData = {24'h0, txBuf};
			`TSE_OFF_RXBUF: next_rdData = {24'h0, rxBuf};
			`TSE_OFF_RXREV: next_rdData = {24'h0, rxRev}; // R10
			`TSE_OFF_TXDIV: next_rdData = {16'h0, txDiv};
			`TSE_OFF_RXDIV: next_rdData = {16'h0, rxDiv};
			default: next_rdData = 32'h0;
		endcase
	end

	// Bus answer and read data
	always @(posedge clock) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= access & hit;
			if (rdStb) begin
				wb_dat_o <= next_rdData;
			end
		end
	end

	// Configuration registers
	always @(posedge clock) begin
		if (!nrst) begin
			ctrl <= `TSE_CTRL_RST;
			txDiv <= `TSE_DIV_RST;
			rxDiv <= `TSE_DIV_RST;
		end else if (wrStb) begin
			if (wb_adr_i == `TSE_OFF_CTRL) begin
				ctrl <= wb_dat_i[3:0];
			end
			if (wb_adr_i == `TSE_OFF_TXDIV && wb_sel_i[1]) begin
				txDiv <= wb_dat_i[15:0];
			end
			if (wb_adr_i == `TSE_OFF_RXDIV && wb_sel_i[1]) begin
				rxDiv <= wb_dat_i[15:0];
			end
		end
	end

	// Transmit buffer: write fills it, the shifter empties it
	assign txLoad = txState[0] & txFull & ctrl[`TSE_CTRL_TXEN]; // R4
	always @(posedge clock) begin
		if (!nrst) begin
			txBuf <= 8'h0;
			txFull <= 1'b0;
		end else if (wrStb && wb_adr_i == `TSE_OFF_TXBUF && txReady) begin
			txBuf <= wb_dat_i[7:0]; // R6
			txFull <= 1'b1;
		end else if (txLoad) begin
			txFull <= 1'b0; // R7
		end
	end

	// Transmit timer and shifter
	assign txTick = (txTimer == 16'h0);
	always @(posedge clock) begin
		if (!nrst) begin
			txState <= TX_IDLE;
			txTimer <= 16'h0;
			txShift <= 8'h0;
			txBit <= 3'h0;
			txPin <= 1'b1;
		end else begin
			txTimer <= txTick ? 16'h0 : txTimer - 16'h1;
			case (txState)
				TX_IDLE: begin
					txPin <= 1'b1; // R14
					if (txLoad) begin
						txShift <= txBuf;
						txPin <= 1'b0; // R2 R14
						txTimer <= txPeriod - 16'h1;
						txState <= TX_START;
					end
				end
				TX_START: begin
					if (txTick) begin
						txPin <= txShift[0]; // R6
						txTimer <= txPeriod - 16'h1;
						txBit <= 3'h0;
						txState <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (txTick) begin
						txTimer <= txPeriod - 16'h1;
						if (txBit == 3'h7) begin
							txPin <= 1'b1; // R1 R2 R3
							txState <= TX_STOP;
						end else begin
							txPin <= txShift[1];
							txShift <= {1'b0, txShift[7:1]};
							txBit <= txBit + 3'h1;
						end
					end
				end
				TX_STOP: begin
					if (txTick) begin
						txState <= TX_IDLE; // R1
					end
				end
				default: begin
					txState <= TX_IDLE;
					txPin <= 1'b1;
				end
			endcase
		end
	end

	// Receive input synchroniser and edge history
	always @(posedge clock) begin
		if (!nrst) begin
			rxMeta <= 1'b1;
			rxSync <= 1'b1;
			rxPrev <= 1'b1;
		end else begin
			rxMeta <= rxPin;
			rxSync <= rxMeta;
			rxPrev <= rxSync;
		end
	end

	// Receive timer: store events at bit middles
	assign rxTick = (rxTimer == 16'h0);
	assign rxStore = rxTick & ~rxState[0]; // R8 R15
	assign rxDone = rxStore & rxState[3];
	always @(posedge clock) begin
		if (!nrst) begin
			rxState <= RX_IDLE;
			rxTimer <= 16'h0;
			rxShift <= 8'h0;
			rxBit <= 3'h0;
		end else begin
			rxTimer <= rxTick ? 16'h0 : rxTimer - 16'h1;
			case (rxState)
				RX_IDLE: begin
					if (ctrl[`TSE_CTRL_RXEN] && rxPrev && !rxSync) begin // R4
						rxTimer <= {1'b0, rxPeriod[15:1]} - 16'h2; // R15
						rxState <= RX_START;
					end
				end
				RX_START: begin
					if (rxStore) begin
						rxTimer <= rxPeriod - 16'h1;
						rxBit <= 3'h0;
						// Glitch rejection: start must still be low
						rxState <= rxSync ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rxStore) begin
						rxShift <= {rxSync, rxShift[7:1]}; // R8
						rxTimer <= rxPeriod - 16'h1;
						rxBit <= rxBit + 3'h1;
						if (rxBit == 3'h7) begin
							rxState <= RX_STOP; // R1
						end
					end
				end
				RX_STOP: begin
					if (rxStore) begin
						rxState <= RX_IDLE;
					end
				end
				default: rxState <= RX_IDLE;
			endcase
		end
	end

	// Receive buffer and flags; a new event wins over a clear
	always @(posedge clock) begin
		if (!nrst) begin
			rxBuf <= 8'h0;
			rxFull <= 1'b0;
			frameErr <= 1'b0;
			rxOvr <= 1'b0;
		end else begin
			if (rdStb && wb_adr_i == `TSE_OFF_RXBUF) begin
				rxFull <= 1'b0;
			end
			if (rdStb && wb_adr_i == `TSE_OFF_RXREV) begin
				rxFull <= 1'b0;
			end
			if (wrStb && wb_adr_i == `TSE_OFF_STAT) begin
				if (wb_dat_i[`TSE_STAT_FRERR]) begin
					frameErr <= 1'b0;
				end
				if (wb_dat_i[`TSE_STAT_RXOVR]) begin
					rxOvr <= 1'b0;
				end
			end
			if (rxDone) begin
				rxBuf <= rxShift; // R8
				rxFull <= 1'b1; // R9
				if (rxFull) begin
					rxOvr <= 1'b1;
				end
				if (!rxSync) begin
					frameErr <= 1'b1; // R11 R12
				end
			end
		end
	end

endmodule

// File: design/tse_uart_consts.vh
// Constants for the timer-and-shifter UART: register map, fields, timing.
// Assumes a 50 MHz system clock and a 32-bit classic Wishbone bus.
`ifndef TSE_UART_CONSTS_VH
`define TSE_UART_CONSTS_VH
// Register byte offsets
`define TSE_OFF_CTRL 5'h00
`define TSE_OFF_STAT 5'h04
`define TSE_OFF_TXBUF 5'h08
`define TSE_OFF_RXBUF 5'h0c
// Offset of the bit-reversed receive buffer view
`define TSE_OFF_RXREV 5'h10
`define TSE_OFF_TXDIV 5'h14
`define TSE_OFF_RXDIV 5'h18
// Control fields
`define TSE_CTRL_TXEN 0
`define TSE_CTRL_RXEN 1
`define TSE_CTRL_TXIE 2
`define TSE_CTRL_RXIE 3
// Status fields
`define TSE_STAT_TXRDY 0
`define TSE_STAT_RXFULL 1
`define TSE_STAT_FRERR 2
`define TSE_STAT_TXBUSY 3
`define TSE_STAT_RXOVR 4
// Reset values
`define TSE_CTRL_RST 4'h0
// Clock and baud figures
`define TSE_CLK_HZ 50000000
`define TSE_MAX_BAUD 115200
// Smallest legal divider: 50 MHz over 115200, rounded down, 16 bits
`define TSE_MIN_DIV 16'h01b2
// Reset divider, one bit period at 115200 baud
`define TSE_DIV_RST 16'h01b2
`endif

// File: tb/tb.sv
// Bench for the timer-and-shifter UART: bus tasks and remote peer.
// Assumes the peer model and bound checker compile first.
`include "tse_uart_consts.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, busErr;
	logic [4:0] adr = 5'h00;
	logic [31:0] wdat = 32'h0, rdat;
	wire [31:0] datOut;
	wire ackOut, errOut, txPin, rxPin, txIrq, rxIrq;
	int err_count = 0, samples_checked = 0, cycles = 0;
	always #10 clock = ~clock;
	tse_uart tse_uart_i (.clock(clock), .nrst(nrst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(datOut), .wb_ack_o(ackOut),
		.wb_err_o(errOut), .txPin(txPin), .rxPin(rxPin),
		.txIrq(txIrq), .rxIrq(rxIrq));
	tse_peer tse_peer_i (.clock(clock), .txPin(txPin), .rxPin(rxPin));
	task automatic chk(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize;
		if (err_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			err_count++;
			summarize();
		end
	end
	// Classic cycle, held until ack or refusal
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// Ack or err ends this wait; the hang guard ends it if neither comes
		do begin
			@(posedge clock);
		end while (ackOut !== 1'b1 && errOut !== 1'b1);
		rdat = datOut;
		busErr = errOut;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e, string s);
		bus(1'b0, a, 32'h0);
		chk(s, rdat, e);
	endtask
	task automatic waitRx(input int cnt);
		while (tse_peer_i.gotCount < cnt)
			@(posedge clock);
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		rd(`TSE_OFF_CTRL, 32'h0, "ctrl");
		rd(`TSE_OFF_STAT, 32'h1, "stat");
		rd(`TSE_OFF_RXDIV, 32'h1b2, "rxdiv");
		bus(1'b0, 5'h1c, 32'h0);
		chk("err range", busErr, 1'b1);
		bus(1'b0, 5'h02, 32'h0);
		chk("err align", busErr, 1'b1);
		// Receive alone, transmitter off
		bus(1'b1, `TSE_OFF_CTRL, 32'ha);
		tse_peer_i.sendByte(8'h3c, 1'b1);
		chk("rx irq", rxIrq, 1'b1);
		rd(`TSE_OFF_STAT, 32'h3, "stat full");
		rd(`TSE_OFF_RXBUF, 32'h3c, "rx byte");
		chk("rx irq low", rxIrq, 1'b0);
		// Bad stop, then a second byte before the first is read
		tse_peer_i.sendByte(8'h13, 1'b0);
		tse_peer_i.sendByte(8'h29, 1'b1);
		rd(`TSE_OFF_STAT, 32'h17, "stat overrun");
		rd(`TSE_OFF_RXREV, 32'h94, "rx mirror");
		rd(`TSE_OFF_STAT, 32'h15, "stat frame");
		bus(1'b1, `TSE_OFF_STAT, 32'h14);
		rd(`TSE_OFF_STAT, 32'h1, "stat clear");
		chk("tx idle", txPin, 1'b1);
		// Divider below the floor: frames still run at the top rate
		bus(1'b1, `TSE_OFF_TXDIV, 32'ha);
		rd(`TSE_OFF_TXDIV, 32'ha, "txdiv");
		// Two frames back to back
		bus(1'b1, `TSE_OFF_CTRL, 32'hf);
		chk("tx irq", txIrq, 1'b1);
		bus(1'b1, `TSE_OFF_TXBUF, 32'h5a);
		rd(`TSE_OFF_STAT, 32'h9, "stat busy");
		bus(1'b1, `TSE_OFF_TXBUF, 32'hc3);
		chk("tx irq full", txIrq, 1'b0);
		waitRx(1);
		chk("tx byte", tse_peer_i.gotByte, 8'h5a);
		chk("tx stop", tse_peer_i.gotStop, 1'b1);
		waitRx(2);
		chk("tx byte 2", tse_peer_i.gotByte, 8'hc3);
		repeat (434) @(posedge clock);
		rd(`TSE_OFF_STAT, 32'h1, "stat idle");
		summarize();
	end
endmodule

// File: tb/tse_peer.sv
// Remote 8N1 serial end: sends frames on rxPin, decodes txPin.
// Times bits in system clock cycles, same divider as the block.
module tse_peer #(parameter int DIV = 434) (
	// System
	input wire clock,
	// Line
	input wire txPin,
	output logic rxPin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] gotByte;
	logic gotStop;
	int gotCount = 0;
	initial rxPin = 1'b1;
	// One frame, stop level chosen by the caller
	task automatic sendByte(input logic [7:0] b, input logic stopBit);
		logic [9:0] f;
		f = {stopBit, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxPin <= f[i];
			repeat (DIV) @(posedge clock);
		end
		rxPin <= 1'b1;
		// One idle bit, so a following frame still shows a start edge
		repeat (DIV) @(posedge clock);
	endtask
	// Decode block frames, sampling mid-bit
	initial forever begin
		@(negedge txPin);
		repeat (DIV / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (DIV) @(posedge clock);
			gotByte[i] = txPin;
		end
		repeat (DIV) @(posedge clock);
		gotStop = txPin;
		gotCount++;
	end
endmodule

// File: tb/tse_uart_monitor.sv
// Checker on the UART ports: bus answers and line bit timing.
// Bound into every tse_uart instance.
module tse_uart_monitor (
	// System
	input wire clock,
	input wire nrst,
	// Bus
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire [4:0] wb_adr_i,
	input wire wb_ack_o,
	input wire wb_err_o,
	// Line
	input wire txPin
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Live request not yet answered
	sequence busReq;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_follows: assert property (busReq ##0 !wb_err_o |=> wb_ack_o)
		else $error("ack missing");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
		else $error("stray ack");
	a_err_align: assert property (busReq ##0 wb_adr_i[1:0] != 2'h0
		|-> wb_err_o) else $error("misaligned not refused");
	a_err_range: assert property (busReq ##0 wb_adr_i > 5'h18 |-> wb_err_o)
		else $error("unmapped not refused");
	a_err_noack: assert property (wb_err_o |=> !wb_ack_o)
		else $error("ack on refused access");
	a_start_hold: assert property ($fell(txPin) |=> !txPin [*8])
		else $error("low bit too short");
	a_bit_hold: assert property ($rose(txPin) |=> txPin [*8])
		else $error("high bit too short");
endmodule

bind tse_uart tse_uart_monitor tse_uart_monitor_i (.clock(clock),
	.nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.txPin(txPin));
